// >>> ebi_top.sv
// External bus interface: space selects, strobes, R/W, wait states, hold.
// Assumes a core request port on SYS_CLK and asynchronous pins READY/HOLD/OFF.
`timescale 1ns/10ps
`include "ebi_defs.svh"
module ebi_top
   import ebi_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic CE_I,
   input wire logic REQ_I,
   input wire logic [1:0] REQ_SPACE_I,
   input wire logic REQ_WRITE_I,
   input wire logic REQ_FETCH_I,
   input wire logic [`EBI_ADDR_W-1:0] REQ_ADDR_I,
   input wire logic [`EBI_DATA_W-1:0] REQ_WDATA_I,
   input wire logic [`EBI_WAIT_W-1:0] WAIT_STATES_I,
   input wire logic READY_I,
   input wire logic HOLD_N_I,
   input wire logic OUT_OFF_N_I,
   input wire logic [`EBI_DATA_W-1:0] DATA_I,
   output logic REQ_BUSY_O,
   output logic REQ_DONE_O,
   output logic [`EBI_DATA_W-1:0] RDATA_O,
   output logic [`EBI_ADDR_W-1:0] ADDR_O,
   output logic ADDR_OE_N_O,
   output logic [`EBI_DATA_W-1:0] DATA_O,
   output logic DATA_OE_N_O,
   output logic DATA_SPACE_SELECT_N_O,
   output logic PROGRAM_SPACE_SELECT_N_O,
   output logic IO_SPACE_SELECT_N_O,
   output logic MEMORY_STROBE_N_O,
   output logic IO_STROBE_N_O,
   output logic RW_O,
   output logic CTRL_OE_N_O,
   output logic MICROSTATE_DONE_N_O,
   output logic HOLD_GRANT_N_O,
   output logic STAT_OE_N_O,
   output logic INSTR_FETCH_FLAG_N_O
);
   // =========================================
   // State record
   typedef struct packed {
      ebi_phase_type phase;
      logic busy;
      logic done;
      logic [`EBI_DATA_W-1:0] rdata;
      logic [`EBI_ADDR_W-1:0] addr;
      logic addr_oe_n;
      logic [`EBI_DATA_W-1:0] wdata;
      logic data_oe_n;
      logic ds_n;
      logic ps_n;
      logic is_n;
      logic memory_strobe_n_n;
      logic io_strobe_n_n;
      logic rw;
      logic ctrl_oe_n;
      logic msc_n;
      logic hold_grant_n_n;
      logic stat_oe_n;
      logic iaq_n;
      logic write;
      logic rdy_check;
      logic rdy_lag;
   } ebi_state_type;

   ebi_state_type st;
   ebi_state_type next_st;
   logic [`EBI_WAIT_W-1:0] waits_left;
   logic load_waits;

   ebi_sync_if sync_bus ();

   // =========================================
   // Pin synchronisers
   ebi_sync i_ebi_sync (
      .clk_i(SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CE_I),
      .pins_i({OUT_OFF_N_I, HOLD_N_I, READY_I}),
      .sync(sync_bus)
   );

   // =========================================
   // Software wait counter
   ebi_wait_cnt i_ebi_wait_cnt (
      .clk_i(SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CE_I),
      .load_i(load_waits),
      .waits_i(WAIT_STATES_I),
      .left_o(waits_left)
   );

   // Load the counter as an access is accepted
   assign load_waits = (st.phase == EBI_IDLE) && REQ_I && sync_bus.hold_req_n;

   // =========================================
   // Next-state logic
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      case (st.phase)
         EBI_IDLE: begin
            // Hold is only granted here, between accesses
            if (!sync_bus.hold_req_n) begin
               next_st.phase = EBI_HOLD;
               next_st.hold_grant_n_n = 1'b0;
               next_st.addr_oe_n = 1'b1;
               next_st.data_oe_n = 1'b1;
               next_st.busy = 1'b1;
            end else if (REQ_I) begin
               next_st.busy = 1'b1;
               next_st.addr = REQ_ADDR_I;
               next_st.wdata = REQ_WDATA_I;
               next_st.write = REQ_WRITE_I;
               next_st.iaq_n = !REQ_FETCH_I;
               next_st.ds_n = (REQ_SPACE_I != `EBI_SPACE_DATA);
               next_st.ps_n = (REQ_SPACE_I != `EBI_SPACE_PROG);
               next_st.is_n = (REQ_SPACE_I != `EBI_SPACE_IO);
               next_st.memory_strobe_n_n = (REQ_SPACE_I == `EBI_SPACE_IO);
               next_st.io_strobe_n_n = (REQ_SPACE_I != `EBI_SPACE_IO);
               next_st.rw = !REQ_WRITE_I;
               next_st.data_oe_n = !REQ_WRITE_I;
               next_st.rdy_check = (WAIT_STATES_I >= `EBI_READY_MIN_WAITS);
               next_st.rdy_lag = 1'b0;
               // One software wait means its last wait is this first one
               next_st.msc_n = !(WAIT_STATES_I >= `EBI_READY_MIN_WAITS &&
                  WAIT_STATES_I == 3'h1);
               next_st.phase = EBI_SW_WAIT;
            end
         end
         EBI_SW_WAIT: begin
            // Counter holds remaining software waits
            next_st.msc_n = !(st.rdy_check && waits_left == 3'h2);
            if (waits_left <= 3'h1) begin
               next_st.msc_n = 1'b1;
               if (st.rdy_check) begin
                  next_st.phase = EBI_RDY_WAIT;
               end else begin
                  next_st.phase = EBI_RDY_WAIT;
               end
            end
         end
         EBI_RDY_WAIT: begin
            // Ready is resampled each cycle until high; MICROSTATE_DONE_N looped back gives one wait.
            // The first edge is skipped: the synchroniser still shows the level from
            // before the last software wait, which would hide a looped-back MICROSTATE_DONE_N.
            if (st.rdy_check && !st.rdy_lag) begin
               next_st.rdy_lag = 1'b1;
            end else if (!st.rdy_check || sync_bus.ready) begin
               next_st.rdy_lag = 1'b0;
               next_st.phase = EBI_IDLE;
               next_st.busy = 1'b0;
               next_st.done = 1'b1;
               next_st.rdata = DATA_I;
               next_st.ds_n = 1'b1;
               next_st.ps_n = 1'b1;
               next_st.is_n = 1'b1;
               next_st.memory_strobe_n_n = 1'b1;
               next_st.io_strobe_n_n = 1'b1;
               next_st.rw = 1'b1;
               next_st.data_oe_n = 1'b1;
               next_st.iaq_n = 1'b1;
            end
         end
         EBI_HOLD: begin
            if (sync_bus.hold_req_n) begin
               next_st.phase = EBI_IDLE;
               next_st.hold_grant_n_n = 1'b1;
               next_st.busy = 1'b0;
               next_st.addr_oe_n = 1'b0;
            end
         end
         default: begin
            next_st.phase = EBI_IDLE;
         end
      endcase
      // Float controls in hold or when outputs are disabled
      next_st.ctrl_oe_n = (next_st.phase == EBI_HOLD) || !sync_bus.out_off_n;
      next_st.stat_oe_n = !sync_bus.out_off_n;
      if (!sync_bus.out_off_n) begin
         next_st.addr_oe_n = 1'b1;
         next_st.data_oe_n = 1'b1;
      end else if (next_st.phase != EBI_HOLD) begin
         next_st.addr_oe_n = 1'b0;
      end
   end

   // =========================================
   // State register; reset floats the bus
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st <= '{phase: EBI_IDLE, busy: 1'b0, done: 1'b0, rdata: '0, addr: '0,
            addr_oe_n: 1'b1, wdata: '0, data_oe_n: 1'b1, ds_n: 1'b1, ps_n: 1'b1,
            is_n: 1'b1, memory_strobe_n_n: 1'b1, io_strobe_n_n: 1'b1, rw: 1'b1, ctrl_oe_n: 1'b1,
            msc_n: 1'b1, hold_grant_n_n: 1'b1, stat_oe_n: 1'b1, iaq_n: 1'b1,
            write: 1'b0, rdy_check: 1'b0, rdy_lag: 1'b0};
      end else if (CE_I) begin
         st <= next_st;
      end
   end

   // =========================================
   // Outputs straight from the state record
   assign REQ_BUSY_O = st.busy;
   assign REQ_DONE_O = st.done;
   assign RDATA_O = st.rdata;
   assign ADDR_O = st.addr;
   assign ADDR_OE_N_O = st.addr_oe_n;
   assign DATA_O = st.wdata;
   assign DATA_OE_N_O = st.data_oe_n;
   assign DATA_SPACE_SELECT_N_O = st.ds_n;
   assign PROGRAM_SPACE_SELECT_N_O = st.ps_n;
   assign IO_SPACE_SELECT_N_O = st.is_n;
   assign MEMORY_STROBE_N_O = st.memory_strobe_n_n;
   assign IO_STROBE_N_O = st.io_strobe_n_n;
   assign RW_O = st.rw;
   assign CTRL_OE_N_O = st.ctrl_oe_n;
   assign MICROSTATE_DONE_N_O = st.msc_n;
   assign HOLD_GRANT_N_O = st.hold_grant_n_n;
   assign STAT_OE_N_O = st.stat_oe_n;
   assign INSTR_FETCH_FLAG_N_O = st.iaq_n;
endmodule : ebi_top

// >>> ebi_defs.svh
// Constants of the external bus interface: field widths, wait-state limits.
// Assumes inclusion by ebi_pkg.sv and the modules; definitions only.
`ifndef EBI_DEFS_SVH
`define EBI_DEFS_SVH
`define EBI_ADDR_W 23
`define EBI_DATA_W 16
`define EBI_WAIT_W 3
`define EBI_READY_MIN_WAITS 3'h2
`define EBI_SPACE_DATA 2'h0
`define EBI_SPACE_PROG 2'h1
`define EBI_SPACE_IO 2'h2
`endif

// >>> ebi_pkg.sv
// Types of the external bus interface.
// Assumes ebi_defs.svh is on the include path.
`include "ebi_defs.svh"
package ebi_pkg;
   typedef enum {
      EBI_IDLE,
      EBI_SW_WAIT,
      EBI_RDY_WAIT,
      EBI_HOLD
   } ebi_phase_type;
endpackage : ebi_pkg

// >>> ebi_sync_if.sv
// Interface carrying synchronised pin levels from the synchroniser to the top.
// Assumes one clock domain.
`timescale 1ns/10ps
interface ebi_sync_if;
   logic ready;
   logic hold_req_n;
   logic out_off_n;
   modport src (output ready, output hold_req_n, output out_off_n);
   modport dst (input ready, input hold_req_n, input out_off_n);
endinterface : ebi_sync_if

// >>> ebi_sync.sv
// Two-flop synchronisers for the asynchronous pins READY, HOLD and OFF.
// Assumes SYS_CLK domain; pins come from outside it.
`timescale 1ns/10ps
module ebi_sync
   import ebi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic [2:0] pins_i,
   ebi_sync_if.src sync
);
   logic [2:0] stage1;
   logic [2:0] stage2;
   // =========================================
   // Synchroniser: first stage read only by the second
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage1 <= 3'h7;
         stage2 <= 3'h7;
      end else if (ce_i) begin
         stage1 <= pins_i;
         stage2 <= stage1;
      end
   end
   assign sync.ready = stage2[0];
   assign sync.hold_req_n = stage2[1];
   assign sync.out_off_n = stage2[2];
endmodule : ebi_sync

// >>> ebi_wait_cnt.sv
// Software wait-state down counter for one access.
// Assumes load pulses at access start; same clock as the top.
`timescale 1ns/10ps
`include "ebi_defs.svh"
module ebi_wait_cnt
   import ebi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [`EBI_WAIT_W-1:0] waits_i,
   output logic [`EBI_WAIT_W-1:0] left_o
);
   logic [`EBI_WAIT_W-1:0] cnt;
   // =========================================
   // Count down to zero; the top reads the remaining count
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt <= '0;
      end else if (ce_i) begin
         if (load_i) begin
            cnt <= waits_i;
         end else if (cnt != '0) begin
            cnt <= cnt - 3'h1;
         end
      end
   end
   assign left_o = cnt;
endmodule : ebi_wait_cnt

// >>> ebi_top_properties.sv
// Concurrent checks on the pins of the external bus interface.
// Assumes binding into ebi_top; one clock, asynchronous low reset.
`timescale 1ns/10ps
`include "ebi_defs.svh"
module ebi_props
   import ebi_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic OUT_OFF_N_I,
   input wire logic [`EBI_WAIT_W-1:0] WAIT_STATES_I,
   input wire logic REQ_BUSY_O,
   input wire logic ADDR_OE_N_O,
   input wire logic DATA_OE_N_O,
   input wire logic DATA_SPACE_SELECT_N_O,
   input wire logic PROGRAM_SPACE_SELECT_N_O,
   input wire logic IO_SPACE_SELECT_N_O,
   input wire logic MEMORY_STROBE_N_O,
   input wire logic IO_STROBE_N_O,
   input wire logic RW_O,
   input wire logic CTRL_OE_N_O,
   input wire logic MICROSTATE_DONE_N_O,
   input wire logic HOLD_GRANT_N_O,
   input wire logic STAT_OE_N_O,
   input wire logic INSTR_FETCH_FLAG_N_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);
   // Shorthands for the select group and the four enables
   wire [2:0] sel_n = {DATA_SPACE_SELECT_N_O, PROGRAM_SPACE_SELECT_N_O, IO_SPACE_SELECT_N_O};
   wire [3:0] oe_n = {ADDR_OE_N_O, DATA_OE_N_O, CTRL_OE_N_O, STAT_OE_N_O};
   // ==========================================
   // Selects, strobes and direction
   a_sel_single: assert property ($onehot0(~sel_n))
      else $error("two space selects low at once");
   a_sel_addr: assert property (sel_n != 3'h7 |-> !ADDR_OE_N_O && REQ_BUSY_O)
      else $error("space select low without an access");
   a_mem_strobe: assert property (!MEMORY_STROBE_N_O |-> sel_n[0] && sel_n[2:1] != 2'h3)
      else $error("memory strobe outside a memory access");
   a_io_strobe: assert property (!IO_STROBE_N_O |-> !sel_n[0] && MEMORY_STROBE_N_O)
      else $error("io strobe outside an io access");
   a_write_dir: assert property (!DATA_OE_N_O || !RW_O |-> !RW_O && REQ_BUSY_O)
      else $error("data driven or write low outside a write");
   a_fetch_flag: assert property (!INSTR_FETCH_FLAG_N_O |-> !MEMORY_STROBE_N_O)
      else $error("fetch flag without a memory access");
   // ==========================================
   // Wait states, hold and output disable
   a_msc_waits: assert property (!MICROSTATE_DONE_N_O |-> WAIT_STATES_I >= `EBI_READY_MIN_WAITS)
      else $error("microstate done with under two waits");
   a_msc_pulse: assert property ($fell(MICROSTATE_DONE_N_O) |=> MICROSTATE_DONE_N_O)
      else $error("microstate done longer than one cycle");
   a_hold_float: assert property (!HOLD_GRANT_N_O [*2] |-> CTRL_OE_N_O && ADDR_OE_N_O)
      else $error("bus still driven in hold");
   a_grant_edge: assert property ($fell(HOLD_GRANT_N_O) |-> $past(MEMORY_STROBE_N_O && IO_STROBE_N_O))
      else $error("hold granted inside a strobed transfer");
   a_off_float: assert property (!OUT_OFF_N_I [*4] |-> oe_n == 4'hF)
      else $error("outputs driven while disabled");
   c_grant: cover property ($fell(HOLD_GRANT_N_O));
   c_msc: cover property ($fell(MICROSTATE_DONE_N_O));
   c_write: cover property (!RW_O && !IO_STROBE_N_O);
endmodule : ebi_props

bind ebi_top ebi_props i_ebi_props (.*);

// >>> ebi_ext_model.sv
// Far-side memories and I/O devices: read data and the ready line.
// Assumes the registered pins of ebi_top; the bench picks the ready mode.
`timescale 1ns/10ps
module ebi_ext_model (
   input wire logic clk_i,
   input wire logic [22:0] addr_i,
   input wire logic strobe_n_i,
   input wire logic rw_i,
   input wire logic msc_n_i,
   input wire logic stat_oe_n_i,
   input wire logic [1:0] mode_i,
   output logic [15:0] data_o,
   output logic ready_o
);
   logic [15:0] last;
   // Idle bus shows the inverse of the last level, so stale data never matches
   always_ff @(posedge clk_i) begin
      last <= data_o;
   end
   assign data_o = (!strobe_n_i && rw_i) ? (addr_i[15:0] ^ 16'hA5A5) : ~last;
   // Mode 0 ready, 1 looped to MICROSTATE_DONE_N (pulled up when floated), 2 not prepared
   assign ready_o = (mode_i == 2'h0) || (mode_i == 2'h1 && (stat_oe_n_i || msc_n_i));
endmodule : ebi_ext_model

// >>> ebi_top_test.sv
// Self-checking bench for ebi_top with the far-side model.
// Assumes the design files compile first; one 10 MHz clock.
`timescale 1ns/10ps
`include "ebi_defs.svh"
module ebi_top_test;
   import ebi_pkg::*;
   typedef struct packed {
      logic [1:0] sp; logic wr; logic fe; logic [2:0] ws; logic [22:0] ad;
      logic [2:0] sel; logic [1:0] stb;
   } ebi_row_type;
   int n_fail = 0, n_checks = 0, n0, n1;
   logic SYS_CLK_I = 1'h0, RST_B_I = 1'h0, CE_I = 1'h1, REQ_I = 1'h0, REQ_WRITE_I = 1'h0;
   logic REQ_FETCH_I = 1'h0, HOLD_N_I = 1'h1, OUT_OFF_N_I = 1'h1, READY_I;
   logic [1:0] REQ_SPACE_I = 2'h0, mode = 2'h0;
   logic [`EBI_ADDR_W-1:0] REQ_ADDR_I = 23'h0, ADDR_O;
   logic [`EBI_DATA_W-1:0] REQ_WDATA_I = 16'h0, DATA_I, RDATA_O, DATA_O;
   logic [`EBI_WAIT_W-1:0] WAIT_STATES_I = 3'h0;
   logic REQ_BUSY_O, REQ_DONE_O, ADDR_OE_N_O, DATA_OE_N_O, DATA_SPACE_SELECT_N_O, RW_O;
   logic PROGRAM_SPACE_SELECT_N_O, IO_SPACE_SELECT_N_O, MEMORY_STROBE_N_O, IO_STROBE_N_O;
   logic CTRL_OE_N_O, MICROSTATE_DONE_N_O, HOLD_GRANT_N_O, STAT_OE_N_O, INSTR_FETCH_FLAG_N_O;
   // Space, write, fetch, waits, address; expected selects and strobes
   ebi_row_type rows [6] = '{
      '{2'h0, 1'h0, 1'h0, 3'h0, 23'h000123, 3'h3, 2'h1},
      '{2'h0, 1'h1, 1'h0, 3'h1, 23'h00FFFF, 3'h3, 2'h1},
      '{2'h1, 1'h0, 1'h1, 3'h2, 23'h7F0ABC, 3'h5, 2'h1},
      '{2'h1, 1'h1, 1'h0, 3'h7, 23'h400000, 3'h5, 2'h1},
      '{2'h2, 1'h0, 1'h0, 3'h3, 23'h00BEEF, 3'h6, 2'h2},
      '{2'h2, 1'h1, 1'h0, 3'h2, 23'h000001, 3'h6, 2'h2}};
   ebi_top i_ebi_top (.*);
   ebi_ext_model i_ebi_ext_model (.clk_i(SYS_CLK_I), .addr_i(ADDR_O),
      .strobe_n_i(MEMORY_STROBE_N_O & IO_STROBE_N_O | CTRL_OE_N_O), .rw_i(RW_O),
      .msc_n_i(MICROSTATE_DONE_N_O), .stat_oe_n_i(STAT_OE_N_O), .mode_i(mode),
      .data_o(DATA_I), .ready_o(READY_I));
   // ==========================================
   // Clock, watchdog and shared tasks
   initial begin
      forever #50 SYS_CLK_I = ~SYS_CLK_I;
   end
   initial begin
      #(100 * 3000);
      n_fail++;
      tally_and_finish;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // Request held one edge only, so the done cycle cannot retake it
   task automatic start(input ebi_row_type r);
      @(negedge SYS_CLK_I);
      {REQ_SPACE_I, REQ_WRITE_I, REQ_FETCH_I, WAIT_STATES_I} = {r.sp, r.wr, r.fe, r.ws};
      REQ_ADDR_I = r.ad;
      REQ_WDATA_I = ~r.ad[15:0];
      REQ_I = 1'h1;
      @(negedge SYS_CLK_I);
      REQ_I = 1'h0;
      chk({DATA_SPACE_SELECT_N_O, PROGRAM_SPACE_SELECT_N_O, IO_SPACE_SELECT_N_O}, r.sel);
      chk(ADDR_O, r.ad);
      chk({MEMORY_STROBE_N_O, IO_STROBE_N_O}, r.stb);
      chk(RW_O, !r.wr);
      chk(DATA_OE_N_O, !r.wr);
      chk(INSTR_FETCH_FLAG_N_O, !r.fe);
      if (r.wr) chk(DATA_O, REQ_WDATA_I);
   endtask : start
   task automatic finish(input ebi_row_type r, output int n);
      n = 1;
      while (REQ_DONE_O !== 1'h1 && n < 40) begin
         @(negedge SYS_CLK_I);
         n++;
      end
      chk(REQ_DONE_O, 1'h1);
      if (!r.wr) chk(RDATA_O, r.ad[15:0] ^ 16'hA5A5);
   endtask : finish
   task automatic run(input ebi_row_type r, output int n);
      start(r);
      finish(r, n);
   endtask : run
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // ==========================================
   // Main sequence: reset, table, then awkward cases
   initial begin
      repeat (20) @(negedge SYS_CLK_I);
      chk({ADDR_OE_N_O, DATA_OE_N_O, CTRL_OE_N_O, STAT_OE_N_O}, 4'hF);
      RST_B_I = 1'h1;
      repeat (5) @(negedge SYS_CLK_I);
      for (int i = 0; i < 6; i++) begin
         run(rows[i], n0);
      end
      // Looping MICROSTATE_DONE_N back to ready costs exactly one more cycle
      run(rows[2], n0);
      mode = 2'h1;
      run(rows[2], n1);
      chk(n1, n0 + 1);
      // Ready is not looked at below two software waits
      mode = 2'h0;
      run(rows[0], n0);
      mode = 2'h2;
      run(rows[0], n1);
      chk(n1, n0);
      // Ready held low stalls the access until released
      start(rows[4]);
      repeat (12) begin
         @(negedge SYS_CLK_I);
         chk(REQ_DONE_O, 1'h0);
      end
      mode = 2'h0;
      finish(rows[4], n1);
      // Hold raised mid-access: the access ends first, then the bus floats
      start(rows[3]);
      HOLD_N_I = 1'h0;
      finish(rows[3], n1);
      repeat (4) @(negedge SYS_CLK_I);
      chk(HOLD_GRANT_N_O, 1'h0);
      chk({ADDR_OE_N_O, DATA_OE_N_O, CTRL_OE_N_O, STAT_OE_N_O}, 4'hE);
      REQ_I = 1'h1;
      repeat (6) begin
         @(negedge SYS_CLK_I);
         chk(REQ_DONE_O, 1'h0);
      end
      REQ_I = 1'h0;
      HOLD_N_I = 1'h1;
      repeat (6) @(negedge SYS_CLK_I);
      chk(HOLD_GRANT_N_O, 1'h1);
      // Output disable floats every enable group
      OUT_OFF_N_I = 1'h0;
      repeat (5) @(negedge SYS_CLK_I);
      chk({ADDR_OE_N_O, DATA_OE_N_O, CTRL_OE_N_O, STAT_OE_N_O}, 4'hF);
      OUT_OFF_N_I = 1'h1;
      repeat (5) @(negedge SYS_CLK_I);
      chk({CTRL_OE_N_O, STAT_OE_N_O}, 2'h0);
      // Reset in mid-access returns the selects high at once
      start(rows[3]);
      RST_B_I = 1'h0;
      @(negedge SYS_CLK_I);
      chk({REQ_BUSY_O, DATA_SPACE_SELECT_N_O, PROGRAM_SPACE_SELECT_N_O, IO_SPACE_SELECT_N_O}, 4'h7);
      RST_B_I = 1'h1;
      repeat (5) @(negedge SYS_CLK_I);
      run(rows[4], n1);
      tally_and_finish;
   end
endmodule : ebi_top_test
